// ---- ppfm_port_mux.v ----
/*
  pin function multiplexer for ports k, ad, m, p, q and s.
  assumes peripherals give their enables, outputs and directions as levels on clk,
  and that the pads resolve out/oe/pullup into a wire outside.
*/
// How it works
// - expanded mode plus page bus: pk7 emulation select
// - pk7 level latched to rom enable on the first clock after reset release
// - pk6 drives external chip select when bus enabled
// - pk5..0 carry extended address bits 19..14
// - port k pull-ups on from reset, software clears
// - digital port ad pins feed keypad wake-up
// - two-wire enable: pm7 clock, pm6 data
// - ports m p q s tri-stated inputs from reset
// - pm5 transmit, pm4 receive per serial2 enables
// - ps3 serial1 transmit when transmitter enabled
// - pm1/pm0 handed to analog outputs when enabled
// - port p pins to pwm outputs, pairwise
// - pq6..4 active-low current status inputs
// - pq3..0 routed as fault inputs
// - spi enable: ps7 slave select, ps6 clock
// - ps5/ps4 direction follows master or slave
// - pm3 stays general-purpose only
`timescale 1ns/1ps
`include "ppfm_defines.vh"
module ppfm_port_mux #(
  parameter PK_W = 8,
  parameter PAD_W = 16,
  parameter PM_W = 8,
  parameter PP_W = 6,
  parameter PQ_W = 7,
  parameter PS_W = 8
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // mode and configuration
  input wire expanded_mode,
  input wire page_pins_bus_enable,
  input wire page_port_pullup_enable_clr,
  input wire page_port_pullup_enable_set,
  // external bus
  input wire emulation_chip_select_n,
  input wire external_chip_select_n,
  input wire [5:0] extended_address_high,
  // port k pads
  input wire [PK_W-1:0] pk_in,
  input wire [PK_W-1:0] pk_dat,
  input wire [PK_W-1:0] pk_dir,
  output wire [PK_W-1:0] pk_out,
  output wire [PK_W-1:0] pk_oe,
  output wire [PK_W-1:0] pk_pullup,
  output wire page_port_pullup_enable,
  output wire onchip_rom_enable,
  // port ad
  input wire [PAD_W-1:0] pad_in,
  input wire [PAD_W-1:0] pad_dat,
  input wire [PAD_W-1:0] pad_dir,
  input wire [PAD_W-1:0] pad_digital_en,
  output wire [PAD_W-1:0] pad_out,
  output wire [PAD_W-1:0] pad_oe,
  output reg [PAD_W-1:0] keypad_wakeup_inputs,
  output wire [PAD_W-1:0] converter_analog_inputs_sel,
  // port m
  input wire [PM_W-1:0] pm_in,
  input wire [PM_W-1:0] pm_dat,
  input wire [PM_W-1:0] pm_dir,
  output wire [PM_W-1:0] pm_out,
  output wire [PM_W-1:0] pm_oe,
  output wire [PM_W-1:0] pm_analog_sel,
  // two-wire interface
  input wire twi_enable,
  input wire twi_scl_drive_low,
  input wire twi_sda_drive_low,
  output reg twi_scl_in,
  output reg twi_sda_in,
  // serial channels
  input wire serial2_tx_enable,
  input wire serial2_rx_enable,
  input wire serial2_transmit,
  output reg serial2_receive,
  input wire serial1_tx_enable,
  input wire serial1_transmit,
  // analog outputs
  input wire analog_out_one_enable,
  input wire analog_out_two_enable,
  // fault-protected pwm
  input wire fault_protected_pwm_module_enable,
  input wire [`PPFM_PWM_PAIRS-1:0] pwm_pair_enable,
  input wire [PP_W-1:0] protected_pwm_outputs,
  input wire current_status_enable,
  input wire [3:0] fault_input_enable,
  output reg [2:0] current_status_inputs_n,
  output reg [3:0] fault_inputs,
  // port p and q
  input wire [PP_W-1:0] pp_in,
  input wire [PP_W-1:0] pp_dat,
  input wire [PP_W-1:0] pp_dir,
  output wire [PP_W-1:0] pp_out,
  output wire [PP_W-1:0] pp_oe,
  input wire [PQ_W-1:0] pq_in,
  input wire [PQ_W-1:0] pq_dat,
  input wire [PQ_W-1:0] pq_dir,
  output wire [PQ_W-1:0] pq_out,
  output wire [PQ_W-1:0] pq_oe,
  // spi and port s
  input wire spi_enable,
  input wire spi_master,
  input wire spi_ss_out_en,
  input wire spi_ss_out,
  input wire spi_sck_out,
  input wire spi_mosi_out,
  input wire spi_miso_out,
  output reg spi_ss_in_n,
  output reg spi_sck_in,
  output reg spi_mosi_in,
  output reg spi_miso_in,
  input wire [PS_W-1:0] ps_in,
  input wire [PS_W-1:0] ps_dat,
  input wire [PS_W-1:0] ps_dir,
  output wire [PS_W-1:0] ps_out,
  output wire [PS_W-1:0] ps_oe
);
  // ===========================================
  // mode decode and port k configuration
  wire bus_pins = expanded_mode & page_pins_bus_enable;
  reg pullup_r;
  reg pullup_nxt;

  always @* begin
    pullup_nxt = pullup_r;
    if (page_port_pullup_enable_set) begin
      pullup_nxt = 1'b1;
    end
    if (page_port_pullup_enable_clr) begin
      pullup_nxt = 1'b0;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pullup_r <= `PPFM_PULLUP_RST;
    end else begin
      pullup_r <= pullup_nxt;
    end
  end
  assign page_port_pullup_enable = pullup_r;
  // pull-ups shown during reset too, without waiting for a clock
  assign pk_pullup = {PK_W{pullup_r | ~resetn}};

  // rom enable follows pk7 strap; only meaningful in expanded modes
  ppfm_strap u_rom_strap (
    .clk(clk),
    .resetn(resetn),
    .strap_in(pk_in[`PPFM_PK_CS_EMU]),
    .strap_q(onchip_rom_enable)
  );

  // ===========================================
  // per-pin select vectors
  wire [PK_W-1:0] pk_sel;
  wire [PK_W-1:0] pk_aout;
  wire [PM_W-1:0] pm_sel;
  wire [PM_W-1:0] pm_aoe;
  wire [PM_W-1:0] pm_aout;
  wire [PP_W-1:0] pp_sel;
  wire [PQ_W-1:0] pq_sel;
  wire [PS_W-1:0] ps_sel;
  wire [PS_W-1:0] ps_aoe;
  wire [PS_W-1:0] ps_aout;

  assign pk_sel = {PK_W{bus_pins}};
  assign pk_aout = {emulation_chip_select_n, external_chip_select_n, extended_address_high};

  // open-drain two-wire pins: enable only while pulling low
  assign pm_sel = {twi_enable, twi_enable, serial2_tx_enable, serial2_rx_enable, 1'b0, 1'b0,
    analog_out_one_enable, analog_out_two_enable};
  assign pm_aoe = {twi_scl_drive_low, twi_sda_drive_low, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  assign pm_aout = {1'b0, 1'b0, serial2_transmit, 5'h00};
  // analog pins have the digital driver off; the analog path takes the pad
  assign pm_analog_sel = {6'h00, analog_out_one_enable, analog_out_two_enable};

  // pwm pins granted pair by pair, or all at once when every pair bit is set
  genvar g;
  generate
    for (g = 0; g < PP_W; g = g + 1) begin : g_pwm
      assign pp_sel[g] = fault_protected_pwm_module_enable & pwm_pair_enable[g / 2];
    end
  endgenerate

  // port q status and fault pins are inputs only while owned by the pwm
  assign pq_sel = {{3{fault_protected_pwm_module_enable & current_status_enable}},
    fault_input_enable & {4{fault_protected_pwm_module_enable}}};

  assign ps_sel = {spi_enable, spi_enable, spi_enable, spi_enable, serial1_tx_enable, 3'h0};
  assign ps_aoe = {spi_master & spi_ss_out_en, spi_master, spi_master, ~spi_master, 1'b1, 3'h0};
  assign ps_aout = {spi_ss_out, spi_sck_out, spi_mosi_out, spi_miso_out, serial1_transmit, 3'h0};

  // ===========================================
  // pad slices; direction registers reset to input outside, so pins float from reset
  generate
    for (g = 0; g < PK_W; g = g + 1) begin : g_pk
      ppfm_gpio_bit u_bit (
        .alt_sel(pk_sel[g] & resetn),
        .alt_oe(1'b1),
        .alt_out(pk_aout[g]),
        .gp_dir(pk_dir[g] & resetn),
        .gp_out(pk_dat[g]),
        .pad_out(pk_out[g]),
        .pad_oe(pk_oe[g])
      );
    end
    for (g = 0; g < PAD_W; g = g + 1) begin : g_pad
      ppfm_gpio_bit u_bit (
        .alt_sel(~pad_digital_en[g]),
        .alt_oe(1'b0),
        .alt_out(1'b0),
        .gp_dir(pad_dir[g] & resetn),
        .gp_out(pad_dat[g]),
        .pad_out(pad_out[g]),
        .pad_oe(pad_oe[g])
      );
    end
    for (g = 0; g < PM_W; g = g + 1) begin : g_pm
      ppfm_gpio_bit u_bit (
        .alt_sel(pm_sel[g] & resetn),
        .alt_oe(pm_aoe[g]),
        .alt_out(pm_aout[g]),
        .gp_dir(pm_dir[g] & resetn),
        .gp_out(pm_dat[g]),
        .pad_out(pm_out[g]),
        .pad_oe(pm_oe[g])
      );
    end
    for (g = 0; g < PP_W; g = g + 1) begin : g_pp
      ppfm_gpio_bit u_bit (
        .alt_sel(pp_sel[g] & resetn),
        .alt_oe(1'b1),
        .alt_out(protected_pwm_outputs[g]),
        .gp_dir(pp_dir[g] & resetn),
        .gp_out(pp_dat[g]),
        .pad_out(pp_out[g]),
        .pad_oe(pp_oe[g])
      );
    end
    for (g = 0; g < PQ_W; g = g + 1) begin : g_pq
      ppfm_gpio_bit u_bit (
        .alt_sel(pq_sel[g] & resetn),
        .alt_oe(1'b0),
        .alt_out(1'b0),
        .gp_dir(pq_dir[g] & resetn),
        .gp_out(pq_dat[g]),
        .pad_out(pq_out[g]),
        .pad_oe(pq_oe[g])
      );
    end
    for (g = 0; g < PS_W; g = g + 1) begin : g_ps
      ppfm_gpio_bit u_bit (
        .alt_sel(ps_sel[g] & resetn),
        .alt_oe(ps_aoe[g]),
        .alt_out(ps_aout[g]),
        .gp_dir(ps_dir[g] & resetn),
        .gp_out(ps_dat[g]),
        .pad_out(ps_out[g]),
        .pad_oe(ps_oe[g])
      );
    end
  endgenerate

  assign converter_analog_inputs_sel = ~pad_digital_en;

  // ===========================================
  // registered input routing to peripherals; idle values when not owned
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      keypad_wakeup_inputs <= {PAD_W{1'b0}};
      twi_scl_in <= 1'b1;
      twi_sda_in <= 1'b1;
      serial2_receive <= 1'b1;
      current_status_inputs_n <= 3'h7;
      fault_inputs <= 4'h0;
      spi_ss_in_n <= 1'b1;
      spi_sck_in <= 1'b0;
      spi_mosi_in <= 1'b0;
      spi_miso_in <= 1'b0;
    end else begin
      keypad_wakeup_inputs <= pad_in & pad_digital_en;
      twi_scl_in <= twi_enable ? pm_in[`PPFM_PM_SCL] : 1'b1;
      twi_sda_in <= twi_enable ? pm_in[`PPFM_PM_SDA] : 1'b1;
      serial2_receive <= serial2_rx_enable ? pm_in[`PPFM_PM_RX2] : 1'b1;
      current_status_inputs_n <= pq_sel[`PPFM_PQ_IS_LO] ?
        pq_in[`PPFM_PQ_IS_HI:`PPFM_PQ_IS_LO] : 3'h7;
      fault_inputs <= pq_in[`PPFM_PQ_FLT_HI:0] & pq_sel[`PPFM_PQ_FLT_HI:0];
      spi_ss_in_n <= spi_enable ? ps_in[`PPFM_PS_SS] : 1'b1;
      spi_sck_in <= spi_enable & ps_in[`PPFM_PS_SCK];
      spi_mosi_in <= spi_enable & ~spi_master & ps_in[`PPFM_PS_MOSI];
      spi_miso_in <= spi_enable & spi_master & ps_in[`PPFM_PS_MISO];
    end
  end
endmodule

// ---- ppfm_defines.vh ----
/*
  constants for the port pin function multiplexer: pin positions, reset values.
  assumes inclusion by bare name from the design files.
*/
`ifndef PPFM_DEFINES_VH
`define PPFM_DEFINES_VH
`define PPFM_PK_CS_EMU 7
`define PPFM_PK_CS_EXT 6
`define PPFM_PK_ADDR_HI 5
`define PPFM_PM_SCL 7
`define PPFM_PM_SDA 6
`define PPFM_PM_TX2 5
`define PPFM_PM_RX2 4
`define PPFM_PM_DAC1 1
`define PPFM_PM_DAC2 0
`define PPFM_PS_SS 7
`define PPFM_PS_SCK 6
`define PPFM_PS_MOSI 5
`define PPFM_PS_MISO 4
`define PPFM_PS_TX1 3
`define PPFM_PQ_IS_HI 6
`define PPFM_PQ_IS_LO 4
`define PPFM_PQ_FLT_HI 3
`define PPFM_PP_PWM_HI 5
`define PPFM_PWM_PAIRS 3
`define PPFM_PULLUP_RST 1'b1
`define PPFM_ROM_RST 1'b0
`endif

// ---- ppfm_gpio_bit.v ----
/*
  one pin slice: chooses between peripheral and port-register control.
  assumes the peripheral select is already decoded by the parent.
*/
`timescale 1ns/1ps
module ppfm_gpio_bit (
  // select
  input wire alt_sel,
  input wire alt_oe,
  input wire alt_out,
  // port registers
  input wire gp_dir,
  input wire gp_out,
  // pad
  output wire pad_out,
  output wire pad_oe
);
  assign pad_oe = alt_sel ? alt_oe : gp_dir;
  assign pad_out = alt_sel ? alt_out : gp_out;
endmodule

// ---- ppfm_strap.v ----
/*
  catches a strap pin on the first clock after reset release.
  assumes the pin is synchronous to clk and held steady across the release.
*/
`timescale 1ns/1ps
`include "ppfm_defines.vh"
module ppfm_strap (
  // clock and reset
  input wire clk,
  input wire resetn,
  // strap
  input wire strap_in,
  output reg strap_q
);
  reg done_r;
  // async reset loads constants only; the pin is sampled on the first edge after release
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_r <= 1'b0;
      strap_q <= `PPFM_ROM_RST;
    end else if (!done_r) begin
      done_r <= 1'b1;
      strap_q <= strap_in;
    end
  end
endmodule

// ---- ppfm_port_mux_properties.sv ----
/*
  checker for the pin function multiplexer, bound to its top.
  assumes pin widths at their default values.
*/
`timescale 1ns/1ps
module ppfm_port_mux_properties (
  // clock and reset
  input wire clk,
  input wire resetn,
  // port k and bus
  input wire expanded_mode,
  input wire page_pins_bus_enable,
  input wire page_port_pullup_enable_clr,
  input wire emulation_chip_select_n,
  input wire [5:0] extended_address_high,
  input wire [7:0] pk_in,
  input wire [7:0] pk_out,
  input wire [7:0] pk_oe,
  input wire [7:0] pk_pullup,
  input wire onchip_rom_enable,
  // port m and s
  input wire [7:0] pm_in,
  input wire [7:0] pm_dat,
  input wire [7:0] pm_dir,
  input wire [7:0] pm_out,
  input wire [7:0] pm_oe,
  input wire serial2_rx_enable,
  input wire serial2_receive,
  input wire analog_out_one_enable,
  input wire spi_enable,
  input wire spi_master,
  input wire [7:0] ps_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire bus = expanded_mode && page_pins_bus_enable;
  sequence s_release;
    !$past(resetn) && resetn;
  endsequence
  a_emu_select: assert property (bus |-> pk_oe[7] && pk_out[7] == emulation_chip_select_n)
    else $error("emulation select wrong");
  a_rom_strap: assert property (s_release |=> onchip_rom_enable == $past(pk_in[7]))
    else $error("rom strap wrong");
  a_addr_high: assert property (bus |-> pk_oe[5:0] == 6'h3f && pk_out[5:0] == extended_address_high)
    else $error("address pins wrong");
  a_pullup_clear: assert property (page_port_pullup_enable_clr |=> pk_pullup == 8'h00)
    else $error("pullups not cleared");
  a_rx2_sample: assert property (serial2_rx_enable |-> !pm_oe[4] ##1 serial2_receive == $past(pm_in[4]))
    else $error("receive pin wrong");
  a_dac1_release: assert property (analog_out_one_enable |-> !pm_oe[1])
    else $error("analog pin driven");
  a_spi_dir: assert property (spi_enable |-> ps_oe[6:4] == {spi_master, spi_master, !spi_master})
    else $error("spi directions wrong");
  a_pm3_plain: assert property (pm_oe[3] == pm_dir[3] && (!pm_dir[3] || pm_out[3] == pm_dat[3]))
    else $error("pin 3 not plain io");
endmodule

bind ppfm_port_mux ppfm_port_mux_properties u_props (.*);

// ---- ppfm_pad_model.sv ----
/*
  far-side pads of port m: devices that drive when the mux does not.
  assumes the bench sets the far-side drive; an undriven line toggles.
*/
`timescale 1ns/1ps
module ppfm_pad_model #(
  parameter W = 8
) (
  // clock
  input wire clk,
  // mux side
  input wire [W-1:0] out,
  input wire [W-1:0] oe,
  // far side
  input wire [W-1:0] ext,
  input wire [W-1:0] ext_oe,
  output logic [W-1:0] pin
);
  logic [W-1:0] last_r = '0;
  // floating line shows a changing level, never a stale one
  always @* begin
    for (int i = 0; i < W; i++)
      pin[i] = oe[i] ? out[i] : ext_oe[i] ? ext[i] : ~last_r[i];
  end
  always @(posedge clk) last_r <= pin;
endmodule

// ---- ppfm_port_mux_bench.sv ----
/*
  self-checking bench for the pin function multiplexer.
  assumes the mux top, its checker and the port m pad model.
*/
`timescale 1ns/1ps
module ppfm_port_mux_bench;
  logic clk = 0, resetn = 0, pu_r, rx_r;
  logic expanded_mode, page_pins_bus_enable, page_port_pullup_enable_clr, page_port_pullup_enable_set;
  logic emulation_chip_select_n, external_chip_select_n, twi_enable, twi_scl_drive_low, twi_sda_drive_low;
  logic serial2_tx_enable, serial2_rx_enable, serial2_transmit, serial1_tx_enable, serial1_transmit;
  logic analog_out_one_enable, analog_out_two_enable, fault_protected_pwm_module_enable, current_status_enable;
  logic spi_enable, spi_master, spi_ss_out_en, spi_ss_out, spi_sck_out, spi_mosi_out, spi_miso_out;
  logic page_port_pullup_enable, onchip_rom_enable, twi_scl_in, twi_sda_in, serial2_receive;
  logic spi_ss_in_n, spi_sck_in, spi_mosi_in, spi_miso_in;
  logic [2:0] pwm_pair_enable, current_status_inputs_n;
  logic [3:0] fault_input_enable, fault_inputs;
  logic [5:0] extended_address_high, protected_pwm_outputs, pp_in, pp_dat, pp_dir, pp_out, pp_oe;
  logic [6:0] pq_in, pq_dat, pq_dir, pq_out, pq_oe;
  logic [7:0] pk_in, pk_dat, pk_dir, pk_out, pk_oe, pk_pullup, pm_ext, pm_ext_oe;
  logic [7:0] pm_in, pm_dat, pm_dir, pm_out, pm_oe, pm_analog_sel, ps_in, ps_dat, ps_dir, ps_out, ps_oe;
  logic [15:0] pad_in, pad_dat, pad_dir, pad_digital_en, pad_out, pad_oe, kw_r;
  logic [15:0] keypad_wakeup_inputs, converter_analog_inputs_sel;
  logic scl_r, miso_r;
  logic [2:0] cs_r;
  logic [3:0] fi_r;
  int seed = 8613, error_cnt = 0, n_checks = 0, cyc = 0;

  ppfm_port_mux DUT (.*);
  ppfm_pad_model u_pads (.clk(clk), .out(pm_out), .oe(pm_oe), .ext(pm_ext), .ext_oe(pm_ext_oe), .pin(pm_in));

  initial begin
    forever #10 clk = ~clk;
  end

  // ==========================================
  // reference model of the registered inputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pu_r <= 1'b1;
      kw_r <= '0;
      rx_r <= 1'b1;
      scl_r <= 1'b1;
      miso_r <= 1'b0;
      cs_r <= 3'h7;
      fi_r <= 4'h0;
    end else begin
      scl_r <= twi_enable ? pm_in[7] : 1'b1;
      miso_r <= spi_enable & spi_master & ps_in[4];
      cs_r <= (fault_protected_pwm_module_enable & current_status_enable) ? pq_in[6:4] : 3'h7;
      fi_r <= pq_in[3:0] & fault_input_enable & {4{fault_protected_pwm_module_enable}};
      pu_r <= page_port_pullup_enable_clr ? 1'b0 : page_port_pullup_enable_set ? 1'b1 : pu_r;
      kw_r <= pad_in & pad_digital_en;
      rx_r <= serial2_rx_enable ? pm_in[4] : 1'b1;
    end
  end

  // ==========================================
  // tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic shake();
    {expanded_mode, page_pins_bus_enable, emulation_chip_select_n, external_chip_select_n, twi_enable,
     twi_scl_drive_low, twi_sda_drive_low, serial2_tx_enable, serial2_rx_enable, serial2_transmit,
     serial1_tx_enable, serial1_transmit, analog_out_one_enable, analog_out_two_enable,
     fault_protected_pwm_module_enable, current_status_enable, spi_enable, spi_master, spi_ss_out_en,
     spi_ss_out, spi_sck_out, spi_mosi_out, spi_miso_out, pwm_pair_enable, fault_input_enable} = 30'($random(seed));
    {extended_address_high, protected_pwm_outputs, pp_in, pp_dat, pp_dir} = 30'($random(seed));
    {pk_in, pk_dat, pk_dir, pm_dat} = $random(seed);
    {pm_dir, ps_in, ps_dat, ps_dir} = $random(seed);
    {pad_in, pad_dat} = $random(seed);
    {pad_dir, pad_digital_en} = $random(seed);
    {pq_in, pq_dat, pq_dir, pm_ext} = 29'($random(seed));
    pm_ext_oe = 8'($random(seed));
    page_port_pullup_enable_clr = ($random(seed) % 16) == 0;
    page_port_pullup_enable_set = ($random(seed) % 8) == 0;
  endtask

  task automatic check_pins();
    logic bus;
    logic [7:0] k, m, s;
    logic [5:0] p;
    logic [6:0] q;
    bus = expanded_mode & page_pins_bus_enable;
    k = bus ? 8'hff : pk_dir;
    m = pm_dir;
    if (twi_enable) m[7:6] = {twi_scl_drive_low, twi_sda_drive_low};
    if (serial2_tx_enable) m[5] = 1'b1;
    if (serial2_rx_enable) m[4] = 1'b0;
    if (analog_out_one_enable) m[1] = 1'b0;
    if (analog_out_two_enable) m[0] = 1'b0;
    p = pp_dir;
    for (int i = 0; i < 6; i++) if (fault_protected_pwm_module_enable && pwm_pair_enable[i/2]) p[i] = 1'b1;
    s = ps_dir;
    if (spi_enable) s[7:4] = {spi_master & spi_ss_out_en, spi_master, spi_master, !spi_master};
    if (serial1_tx_enable) s[3] = 1'b1;
    q = pq_dir & ~{{3{fault_protected_pwm_module_enable & current_status_enable}},
      fault_input_enable & {4{fault_protected_pwm_module_enable}}};
    check(pq_oe, q);
    check(ps_out[3] & s[3], (serial1_tx_enable ? serial1_transmit : ps_dat[3]) & s[3]);
    check(pk_oe, k);
    check(pk_out & k, bus ? {emulation_chip_select_n, external_chip_select_n, extended_address_high} : pk_dat & k);
    check(pm_oe, m);
    check(pp_oe, p);
    check(ps_oe, s);
    check(pad_oe, pad_digital_en & pad_dir);
  endtask

  task automatic do_reset();
    @(negedge clk) resetn = 0;
    repeat (16) begin
      @(negedge clk);
      shake();
      #5;
      check(pk_oe | pm_oe | ps_oe | pp_oe | pq_oe, 8'h00);
      check(pk_pullup, 8'hff);
      check(onchip_rom_enable, 1'b0);
    end
    // strap pin held still across the release edge
    @(negedge clk) resetn = 1;
    @(negedge clk) check(onchip_rom_enable, pk_in[7]);
    $display("reset phase done");
  endtask

  // ==========================================
  // main sequence, second pass is a mid-run reset
  initial begin
    for (int t = 0; t < 2; t++) begin
      do_reset();
      repeat (200) begin
        @(negedge clk);
        check(pk_pullup, {8{pu_r}});
        check(keypad_wakeup_inputs, kw_r);
        check(serial2_receive, rx_r);
        check(twi_scl_in, scl_r);
        check(current_status_inputs_n, cs_r);
        check(fault_inputs, fi_r);
        check(spi_miso_in, miso_r);
        shake();
        #5 check_pins();
      end
      $display("random phase done");
    end
    close_out();
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      close_out();
    end
  end
endmodule
